// File: design/cca_pkg.sv
package cca_pkg;
   localparam int NUM_CH = 6;
   // register byte addresses on the AXI4-Lite bus
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_PWM = 8'h04;
   localparam logic [7:0] ADDR_COUNT = 8'h08;
   localparam logic [7:0] ADDR_MODE0 = 8'h10;
   localparam logic [7:0] ADDR_CMPL0 = 8'h30;
   localparam logic [7:0] ADDR_CMPH0 = 8'h50;
   localparam logic [7:0] ADDR_STRIDE = 8'h04;
   // array_control_reg fields
   localparam int CTRL_CH_FLAG = 0;
   localparam int CTRL_RUN = 6;
   localparam int CTRL_OVF_FLAG = 7;
   localparam int CTRL_OVF_IEN = 8;
   localparam int CTRL_ARRAY_IEN = 9;
   localparam int CTRL_GLOBAL_IEN = 10;
   // channel_mode_reg fields
   localparam int MODE_IEN = 0;
   localparam int MODE_PWM = 1;
   localparam int MODE_TOG = 2;
   localparam int MODE_MAT = 3;
   localparam int MODE_FALL = 4;
   localparam int MODE_RISE = 5;
   localparam int MODE_CMP = 6;
   localparam int MODE_WIDE = 7;
   // pulse_config_reg fields
   localparam int PWM_CYCLE_LENGTH_SEL = 0;
   localparam int PWM_MID_IEN = 5;
   localparam int PWM_MID_FLAG = 6;
   localparam int PWM_RELOAD_VIEW_SEL = 7;
   localparam logic [31:0] RESET_VALUE = 32'h0000_0000;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// File: design/cca_top.sv
`timescale 1ns/1ps
module cca_top
(
   input wire logic REF_CLK,
   input wire logic SYS_RST,
   input wire logic [7:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [7:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   input wire logic [5:0] CHANNEL_PIN_IN,
   output logic [5:0] CHANNEL_PIN_OUT,
   output logic [5:0] CHANNEL_PIN_OE_N,
   output logic IRQ
);
   localparam int N = cca_pkg::NUM_CH;
   logic [15:0] count;
   logic run;
   logic ovf_flag, mid_flag, ovf_ien, mid_ien, array_ien, global_ien, reload_view_sel;
   logic [1:0] cycle_length_sel;
   logic [5:0] ch_flag;
   logic [7:0] mode [N];
   logic [15:0] cmp [N];
   logic [15:0] reload [N];
   logic [5:0] pin_q;
   logic [5:0] s1, s2, s3, stable;
   logic [5:0] ch_event;
   logic mid_ovf, ovf_evt;
   // bus write channel state
   logic aw_held, w_held;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic wr_go;
   logic [7:0] rd_addr_q;
   logic [31:0] rd_word;
   logic rd_ok;

   assign S_AXI_AWREADY = !aw_held && !S_AXI_BVALID;
   assign S_AXI_WREADY = !w_held && !S_AXI_BVALID;
   assign S_AXI_ARREADY = !S_AXI_RVALID;
   assign wr_go = aw_held && w_held && !S_AXI_BVALID;

   always_ff @(posedge REF_CLK)
   begin
      if (SYS_RST)
      begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         S_AXI_BVALID <= 1'b0;
         S_AXI_BRESP <= cca_pkg::RESP_OKAY;
      end
      else
      begin
         if (S_AXI_AWVALID && S_AXI_AWREADY)
         begin
            aw_held <= 1'b1;
            aw_addr <= S_AXI_AWADDR;
         end
         if (S_AXI_WVALID && S_AXI_WREADY)
         begin
            w_held <= 1'b1;
            w_data <= S_AXI_WDATA;
            w_strb <= S_AXI_WSTRB;
         end
         if (wr_go)
         begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP <= addr_ok(aw_addr) ? cca_pkg::RESP_OKAY : cca_pkg::RESP_SLVERR;
         end
         else if (S_AXI_BREADY)
            S_AXI_BVALID <= 1'b0;
      end
   end

   function automatic logic addr_ok(input logic [7:0] a);
      addr_ok = (a == cca_pkg::ADDR_CTRL) || (a == cca_pkg::ADDR_PWM) || (a == cca_pkg::ADDR_COUNT)
         || (a >= cca_pkg::ADDR_MODE0 && a < cca_pkg::ADDR_MODE0 + 8'(N * 4) && a[1:0] == 2'b00)
         || (a >= cca_pkg::ADDR_CMPL0 && a < cca_pkg::ADDR_CMPL0 + 8'(N * 4) && a[1:0] == 2'b00)
         || (a >= cca_pkg::ADDR_CMPH0 && a < cca_pkg::ADDR_CMPH0 + 8'(N * 4) && a[1:0] == 2'b00);
   endfunction

   // pin synchroniser; a level counts once the second and third stages agree
   always_ff @(posedge REF_CLK)
   begin
      if (SYS_RST)
      begin
         s1 <= 6'h00;
         s2 <= 6'h00;
         s3 <= 6'h00;
         stable <= 6'h00;
      end
      else
      begin
         s1 <= CHANNEL_PIN_IN;
         s2 <= s1;
         s3 <= s2;
         stable <= (s2 & s3) | (stable & (s2 | s3));
      end
   end

   // counter and overflow detection
   assign ovf_evt = run && (count == 16'hFFFF);
   always_comb
   begin
      case (cycle_length_sel)
         2'b00: mid_ovf = run && (count[7:0] == 8'hFF);
         2'b01: mid_ovf = run && (count[8:0] == 9'h1FF);
         2'b10: mid_ovf = run && (count[9:0] == 10'h3FF);
         default: mid_ovf = run && (count[10:0] == 11'h7FF);
      endcase
   end

   always_ff @(posedge REF_CLK)
   begin
      if (SYS_RST)
         count <= 16'h0000;
      else if (wr_go && aw_addr == cca_pkg::ADDR_COUNT && w_strb[0])
         count <= w_data[15:0];
      else if (run)
         count <= count + 16'h0001;
   end

   logic wr_ctrl, wr_pwm;
   assign wr_ctrl = wr_go && aw_addr == cca_pkg::ADDR_CTRL;
   assign wr_pwm = wr_go && aw_addr == cca_pkg::ADDR_PWM;

   always_ff @(posedge REF_CLK)
   begin
      if (SYS_RST)
      begin
         run <= 1'b0;
         ovf_flag <= 1'b0;
         ovf_ien <= 1'b0;
         array_ien <= 1'b0;
         global_ien <= 1'b0;
         mid_flag <= 1'b0;
         mid_ien <= 1'b0;
         reload_view_sel <= 1'b0;
         cycle_length_sel <= 2'b00;
      end
      else
      begin
         if (wr_ctrl && w_strb[0])
            run <= w_data[cca_pkg::CTRL_RUN];
         if (wr_ctrl && w_strb[1])
         begin
            ovf_ien <= w_data[cca_pkg::CTRL_OVF_IEN];
            array_ien <= w_data[cca_pkg::CTRL_ARRAY_IEN];
            global_ien <= w_data[cca_pkg::CTRL_GLOBAL_IEN];
         end
         // wrap sets flag, set beats clear
         if (ovf_evt)
            ovf_flag <= 1'b1;
         else if (wr_ctrl && w_strb[0] && !w_data[cca_pkg::CTRL_OVF_FLAG])
            ovf_flag <= 1'b0;
         if (wr_pwm && w_strb[0])
         begin
            reload_view_sel <= w_data[cca_pkg::PWM_RELOAD_VIEW_SEL];
            mid_ien <= w_data[cca_pkg::PWM_MID_IEN];
            cycle_length_sel <= w_data[cca_pkg::PWM_CYCLE_LENGTH_SEL +: 2];
         end
         if (mid_ovf)
            mid_flag <= 1'b1;
         else if (wr_pwm && w_strb[0] && !w_data[cca_pkg::PWM_MID_FLAG])
            mid_flag <= 1'b0;
      end
   end

   // narrow pwm window mask from shared cycle length
   logic [15:0] pwm_mask;
   assign pwm_mask = 16'((17'h00100 << cycle_length_sel) - 17'h00001);

   genvar g;
   generate
      for (g = 0; g < N; g++)
      begin : gen_ch
         logic [7:0] md;
         logic cmp_on, is_cap, is_pwm, match16, match_lo, edge_ok, cap_evt, match_evt;
         logic prev;
         logic wr_mode, wr_lo, wr_hi;
         assign md = mode[g];
         assign cmp_on = md[cca_pkg::MODE_CMP];
         assign is_cap = md[3:1] == 3'b000 && (md[cca_pkg::MODE_RISE] || md[cca_pkg::MODE_FALL]);
         assign is_pwm = cmp_on && md[cca_pkg::MODE_PWM] && !md[cca_pkg::MODE_TOG];
         assign match16 = run && cmp_on && count == cmp[g];
         assign match_lo = md[cca_pkg::MODE_WIDE] ? match16
            : run && cmp_on && (count & pwm_mask) == (cmp[g] & pwm_mask);
         assign edge_ok = (md[cca_pkg::MODE_RISE] && stable[g] && !prev)
            || (md[cca_pkg::MODE_FALL] && !stable[g] && prev);
         assign cap_evt = is_cap && edge_ok;
         assign match_evt = md[cca_pkg::MODE_MAT] && (is_pwm ? match_lo : match16);
         assign ch_event[g] = cap_evt || match_evt;
         assign wr_mode = wr_go && aw_addr == cca_pkg::ADDR_MODE0 + 8'(g * 4) && w_strb[0];
         assign wr_lo = wr_go && aw_addr == cca_pkg::ADDR_CMPL0 + 8'(g * 4) && w_strb[0];
         assign wr_hi = wr_go && aw_addr == cca_pkg::ADDR_CMPH0 + 8'(g * 4) && w_strb[0];

         always_ff @(posedge REF_CLK)
         begin
            if (SYS_RST)
               prev <= 1'b0;
            else
               prev <= stable[g];
         end

         always_ff @(posedge REF_CLK)
         begin
            if (SYS_RST)
            begin
               mode[g] <= 8'h00;
               cmp[g] <= 16'h0000;
               reload[g] <= 16'h0000;
            end
            else
            begin
               if (wr_mode)
                  mode[g] <= w_data[7:0];
               else if (wr_lo)
                  mode[g][cca_pkg::MODE_CMP] <= 1'b0;
               else if (wr_hi)
                  mode[g][cca_pkg::MODE_CMP] <= 1'b1;
               if (wr_lo && reload_view_sel)
                  reload[g][7:0] <= w_data[7:0];
               if (wr_hi && reload_view_sel)
                  reload[g][15:8] <= w_data[7:0];
               if (cap_evt)
                  cmp[g] <= count;
               else if (wr_lo && !reload_view_sel)
                  cmp[g][7:0] <= w_data[7:0];
               else if (wr_hi && !reload_view_sel)
                  cmp[g][15:8] <= w_data[7:0];
               // advance low byte by high byte offset
               else if (cmp_on && md[cca_pkg::MODE_TOG] && md[cca_pkg::MODE_PWM] && run
                  && count[7:0] == cmp[g][7:0])
                  cmp[g][7:0] <= cmp[g][7:0] + cmp[g][15:8];
               // narrow pwm reload at window overflow
               else if (is_pwm && !md[cca_pkg::MODE_WIDE] && mid_ovf)
                  cmp[g] <= (cycle_length_sel == 2'b00) ? {cmp[g][15:8], cmp[g][15:8]} : reload[g];
            end
         end

         always_ff @(posedge REF_CLK)
         begin
            if (SYS_RST)
               pin_q[g] <= 1'b0;
            else if (!cmp_on)
               pin_q[g] <= is_pwm || md[cca_pkg::MODE_PWM] && !md[cca_pkg::MODE_TOG] ? 1'b0 : pin_q[g];
            else if (md[cca_pkg::MODE_TOG] && !md[cca_pkg::MODE_PWM] && match16)
               pin_q[g] <= !pin_q[g];
            else if (md[cca_pkg::MODE_TOG] && md[cca_pkg::MODE_PWM] && run && count[7:0] == cmp[g][7:0])
               pin_q[g] <= !pin_q[g];
            else if (is_pwm && (md[cca_pkg::MODE_WIDE] ? ovf_evt : mid_ovf))
               pin_q[g] <= 1'b0;
            else if (is_pwm && match_lo)
               pin_q[g] <= 1'b1;
         end

         always_ff @(posedge REF_CLK)
         begin
            if (SYS_RST)
               ch_flag[g] <= 1'b0;
            else if (ch_event[g])
               ch_flag[g] <= 1'b1;
            else if (wr_ctrl && w_strb[0] && !w_data[cca_pkg::CTRL_CH_FLAG + g])
               ch_flag[g] <= 1'b0;
         end

         assign CHANNEL_PIN_OUT[g] = pin_q[g];
         assign CHANNEL_PIN_OE_N[g] = is_cap;
      end
   endgenerate

   logic [5:0] ch_ien;
   always_comb
   begin
      for (int i = 0; i < N; i++)
         ch_ien[i] = mode[i][cca_pkg::MODE_IEN];
   end
   always_ff @(posedge REF_CLK)
   begin
      if (SYS_RST)
         IRQ <= 1'b0;
      else
         IRQ <= global_ien && array_ien
            && ((ovf_flag && ovf_ien) || (mid_flag && mid_ien) || |(ch_flag & ch_ien));
   end

   // read channel
   always_comb
   begin
      rd_word = cca_pkg::RESET_VALUE;
      rd_ok = 1'b1;
      case (S_AXI_ARADDR)
         cca_pkg::ADDR_CTRL:
            rd_word = {21'h0, global_ien, array_ien, ovf_ien, ovf_flag, run, ch_flag};
         cca_pkg::ADDR_PWM:
            rd_word = {24'h0, reload_view_sel, mid_flag, mid_ien, 3'h0, cycle_length_sel};
         cca_pkg::ADDR_COUNT:
            rd_word = {16'h0, count};
         default:
         begin
            rd_ok = addr_ok(S_AXI_ARADDR);
            for (int i = 0; i < N; i++)
            begin
               if (S_AXI_ARADDR == cca_pkg::ADDR_MODE0 + 8'(i * 4))
                  rd_word = {24'h0, mode[i]};
               if (S_AXI_ARADDR == cca_pkg::ADDR_CMPL0 + 8'(i * 4))
                  rd_word = {24'h0, reload_view_sel ? reload[i][7:0] : cmp[i][7:0]};
               if (S_AXI_ARADDR == cca_pkg::ADDR_CMPH0 + 8'(i * 4))
                  rd_word = {24'h0, reload_view_sel ? reload[i][15:8] : cmp[i][15:8]};
            end
         end
      endcase
   end

   always_ff @(posedge REF_CLK)
   begin
      if (SYS_RST)
      begin
         S_AXI_RVALID <= 1'b0;
         S_AXI_RDATA <= 32'h0000_0000;
         S_AXI_RRESP <= cca_pkg::RESP_OKAY;
         rd_addr_q <= 8'h00;
      end
      else if (S_AXI_ARVALID && S_AXI_ARREADY)
      begin
         S_AXI_RVALID <= 1'b1;
         S_AXI_RDATA <= rd_ok ? rd_word : 32'h0000_0000;
         S_AXI_RRESP <= rd_ok ? cca_pkg::RESP_OKAY : cca_pkg::RESP_SLVERR;
         rd_addr_q <= S_AXI_ARADDR;
      end
      else if (S_AXI_RREADY)
         S_AXI_RVALID <= 1'b0;
   end

   // assertions
   irq_gate_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      IRQ |-> $past(global_ien) && $past(array_ien)) else $error("irq without global enables");
   ovf_set_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      ovf_evt |=> ovf_flag && count == 16'h0000) else $error("overflow flag not set on wrap");
   mid_set_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      mid_ovf |=> mid_flag) else $error("intermediate flag not set");
   ch_hold_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      ch_flag[1] && !wr_ctrl |=> ch_flag[1]) else $error("channel flag dropped without write");
   ch_set_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      ch_event[1] |=> ch_flag[1]) else $error("channel event lost");
   lo_clear_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      gen_ch[1].wr_lo && !gen_ch[1].wr_mode |=> !mode[1][cca_pkg::MODE_CMP])
      else $error("low write kept comparator");
   hi_set_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      gen_ch[1].wr_hi |=> mode[1][cca_pkg::MODE_CMP]) else $error("high write missed comparator");
   cap_load_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      gen_ch[3].cap_evt |=> cmp[3] == $past(count)) else $error("capture value wrong");
   hs_toggle_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      gen_ch[2].md[cca_pkg::MODE_TOG] && !gen_ch[2].md[cca_pkg::MODE_PWM] && gen_ch[2].match16
      |=> CHANNEL_PIN_OUT[2] != $past(CHANNEL_PIN_OUT[2])) else $error("pin did not toggle");
endmodule

// File: bench/cca_pin_model.sv
`timescale 1ns/1ps
module cca_pin_model
(
   input wire logic [5:0] ext_level,
   input wire logic [5:0] pin_out,
   input wire logic [5:0] pin_oe_n,
   output logic [5:0] pin_in
);
   always_comb
   begin
      for (int i = 0; i < 6; i++)
      begin
         pin_in[i] = pin_oe_n[i] ? ext_level[i] : pin_out[i];
      end
   end
endmodule

// File: bench/counter_array_capture_compare_test.sv
`timescale 1ns/1ps
module counter_array_capture_compare_test;
   localparam logic [7:0] A_CTRL = cca_pkg::ADDR_CTRL;
   localparam logic [7:0] A_PWM = cca_pkg::ADDR_PWM;
   localparam logic [7:0] A_CNT = cca_pkg::ADDR_COUNT;
   localparam logic [1:0] ERR = cca_pkg::RESP_SLVERR;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, irq;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [5:0] ext = 6'h00;
   logic [5:0] pin_in, pin_out, pin_oe_n;
   logic [33:0] exp_q[$];
   int n_errors = 0;
   int tests_run = 0;

   cca_top cca_top_i (.REF_CLK(clk), .SYS_RST(rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
      .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
      .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
      .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .CHANNEL_PIN_IN(pin_in),
      .CHANNEL_PIN_OUT(pin_out), .CHANNEL_PIN_OE_N(pin_oe_n), .IRQ(irq));
   cca_pin_model cca_pin_model_i (.ext_level(ext), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_in(pin_in));

   initial
   begin
      forever #2.5 clk = ~clk;
   end

   function automatic logic [7:0] ch(input logic [7:0] base, input int n);
      return base + 8'(4 * n);
   endfunction

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic check(input string what, input logic [33:0] seen, input logic [33:0] expv);
      tests_run++;
      if (seen !== expv)
      begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", what, expv, seen);
      end
   endtask

   task automatic timed_out();
      n_errors++;
      $display("ERROR wait bound used up");
      end_of_test();
   endtask

   // master: handshakes are judged at the falling edge, released after the rising one
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'b00);
      int n;
      logic aw_go, w_go, b_go;
      b_go = 1'b0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 50 && !b_go; n++)
      begin
         @(negedge clk);
         aw_go = awvalid && awready;
         w_go = wvalid && wready;
         b_go = bvalid;
         if (b_go)
            check("write response", {32'h0, bresp}, {32'h0, er});
         @(posedge clk);
         if (aw_go)
            awvalid <= 1'b0;
         if (w_go)
            wvalid <= 1'b0;
         if (b_go)
            bready <= 1'b0;
      end
      // one idle edge so the next call never reassigns a strobe in this time step
      @(posedge clk);
      if (!b_go)
         timed_out();
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'b00);
      int n;
      logic ar_go, r_go;
      r_go = 1'b0;
      exp_q.push_back({er, d});
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 50 && !r_go; n++)
      begin
         @(negedge clk);
         ar_go = arvalid && arready;
         r_go = rvalid;
         @(posedge clk);
         if (ar_go)
            arvalid <= 1'b0;
         if (r_go)
            rready <= 1'b0;
      end
      @(posedge clk);
      if (!r_go)
         timed_out();
   endtask

   always @(posedge clk)
   begin
      if (rvalid && rready)
      begin
         if (exp_q.size() == 0)
            check("unexpected read", 34'h1, 34'h0);
         else
            check("read data", {rresp, rdata}, exp_q.pop_front());
      end
   end

   task automatic run_for(input logic [15:0] start, input int cyc);
      wr(A_CNT, {16'h0, start});
      wr(A_CTRL, 32'hFF);
      repeat (cyc) @(posedge clk);
      wr(A_CTRL, 32'hBF);
   endtask

   task automatic drive_pin(input int n, input logic lv);
      ext[n] <= lv;
      repeat (8) @(posedge clk);
   endtask

   task automatic toggle_gap(input int n, output int cnt);
      logic p;
      p = pin_out[n];
      cnt = 0;
      do
      begin
         @(negedge clk);
         cnt++;
      end while (pin_out[n] === p && cnt < 600);
      if (cnt >= 600)
         timed_out();
   endtask

   initial
   begin
      logic [15:0] v;
      int per;
      v = 16'($urandom(75));
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      check("pins after reset", {26'h0, pin_oe_n, pin_out}, 34'h0);
      rd(A_CTRL, 32'h0);
      rd(ch(cca_pkg::ADDR_MODE0, 0), 32'h0);
      rd(8'hFC, 32'h0, ERR);
      wr(8'hFC, 32'h0, ERR);
      $display("reset and map done");
      run_for(16'hFFF0, 40);
      rd(A_CTRL, 32'h80);
      for (int k = 0; k < 8; k++)
      begin
         wr(A_CTRL, {21'h0, 3'(k), 8'hBF});
         repeat (3) @(posedge clk);
         check("irq", {33'h0, irq}, {33'h0, k == 7});
      end
      wr(A_CTRL, 32'h73F);
      repeat (3) @(posedge clk);
      check("irq after clear", {33'h0, irq}, 34'h0);
      rd(A_CTRL, 32'h700);
      wr(A_CTRL, 32'h0);
      $display("overflow and interrupt done");
      wr(ch(cca_pkg::ADDR_MODE0, 1), 32'h48);
      wr(ch(cca_pkg::ADDR_CMPL0, 1), 32'h20);
      rd(ch(cca_pkg::ADDR_MODE0, 1), 32'h08);
      wr(ch(cca_pkg::ADDR_CMPH0, 1), 32'h01);
      rd(ch(cca_pkg::ADDR_MODE0, 1), 32'h48);
      run_for(16'h0100, 60);
      repeat (20) @(posedge clk);
      rd(A_CTRL, 32'h02);
      wr(ch(cca_pkg::ADDR_MODE0, 1), 32'h0);
      wr(A_CTRL, 32'h0);
      $display("software timer done");
      v = 16'h0010 + 16'($urandom % 48);
      wr(ch(cca_pkg::ADDR_MODE0, 2), 32'h4C);
      wr(ch(cca_pkg::ADDR_CMPL0, 2), {24'h0, v[7:0]});
      wr(ch(cca_pkg::ADDR_CMPH0, 2), {24'h0, v[15:8]});
      run_for(16'h0, 100);
      check("toggle pin", {32'h0, pin_oe_n[2], pin_out[2]}, 34'h1);
      rd(A_CTRL, 32'h04);
      wr(ch(cca_pkg::ADDR_CMPL0, 2), {24'h0, v[7:0]});
      run_for(16'h0, 100);
      check("toggle pin held", {33'h0, pin_out[2]}, 34'h1);
      wr(A_CTRL, 32'h0);
      $display("high speed output done");
      v = 16'($urandom);
      wr(A_CNT, {16'h0, v});
      wr(ch(cca_pkg::ADDR_MODE0, 3), 32'h20);
      check("capture pin released", {33'h0, pin_oe_n[3]}, 34'h1);
      drive_pin(3, 1'b1);
      rd(ch(cca_pkg::ADDR_CMPL0, 3), {24'h0, v[7:0]});
      rd(ch(cca_pkg::ADDR_CMPH0, 3), {24'h0, v[15:8]});
      rd(A_CTRL, 32'h08);
      wr(A_CTRL, 32'h0);
      drive_pin(3, 1'b0);
      rd(A_CTRL, 32'h0);
      wr(ch(cca_pkg::ADDR_MODE0, 3), 32'h10);
      drive_pin(3, 1'b1);
      rd(A_CTRL, 32'h0);
      drive_pin(3, 1'b0);
      rd(A_CTRL, 32'h08);
      wr(A_CTRL, 32'h0);
      $display("capture done");
      wr(ch(cca_pkg::ADDR_MODE0, 4), 32'h46);
      for (int j = 0; j < 2; j++)
      begin
         wr(ch(cca_pkg::ADDR_CMPL0, 4), 32'h0);
         wr(ch(cca_pkg::ADDR_CMPH0, 4), j ? 32'h0 : 32'h3);
         wr(A_CTRL, 32'h40);
         toggle_gap(4, per);
         toggle_gap(4, per);
         check("frequency half period", 34'(per), j ? 34'd256 : 34'd3);
         wr(A_CTRL, 32'h0);
      end
      wr(ch(cca_pkg::ADDR_MODE0, 4), 32'h0);
      $display("frequency output done");
      wr(ch(cca_pkg::ADDR_MODE0, 5), 32'hCA);
      wr(ch(cca_pkg::ADDR_CMPL0, 5), 32'h10);
      wr(ch(cca_pkg::ADDR_CMPH0, 5), 32'h00);
      run_for(16'h0, 60);
      check("wide pulse high", {33'h0, pin_out[5]}, 34'h1);
      rd(A_CTRL, 32'h20);
      wr(ch(cca_pkg::ADDR_CMPL0, 5), 32'h10);
      repeat (3) @(posedge clk);
      check("pulse off low", {33'h0, pin_out[5]}, 34'h0);
      wr(ch(cca_pkg::ADDR_MODE0, 5), 32'h0);
      wr(A_CTRL, 32'h0);
      for (int k = 0; k < 4; k++)
      begin
         wr(A_PWM, 32'(k));
         run_for(16'((17'h1 << (8 + k)) - 4), 20);
         rd(A_PWM, 32'h40 | 32'(k));
      end
      wr(A_PWM, 32'h80);
      wr(ch(cca_pkg::ADDR_CMPL0, 0), 32'h5A);
      rd(ch(cca_pkg::ADDR_CMPL0, 0), 32'h5A);
      wr(A_PWM, 32'h0);
      rd(ch(cca_pkg::ADDR_CMPL0, 0), 32'h0);
      $display("pulse modes done");
      repeat (4) @(posedge clk);
      end_of_test();
   end
endmodule
